/* File: dv/dpd_asserts.sv */
// Purpose: port assertions for the dual pipe dispatch block
// Assumes: event outputs lag their cause by one clock
// Notes: bound onto every dual_pipe_dispatch instance
`timescale 1ns/1ps
module dpd_asserts #(
	parameter [2:0] DEPTH_MAX = 3'h4
) (
	input wire CLK,
	input wire RST_N,
	input wire FETCH_VALID,
	input wire BR_RESOLVE,
	input wire BR_MISPRED,
	input wire FP_DONE,
	input wire WBUF_FULL,
	input wire FETCH_ACK,
	input wire FLUSH,
	input wire CKPT_SAVE,
	input wire CKPT_FREE,
	input wire CKPT_RESTORE,
	input wire [2:0] SPEC_DEPTH,
	input wire EX_ASSIST,
	input wire OOO_COMPLETE,
	input wire [1:0] WBUF_PUSH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	AST_DEPTH_LIMIT: assert property (SPEC_DEPTH <= DEPTH_MAX)
		else $error("depth above limit");
	AST_RESET_CLEAR: assert property ($rose(RST_N) |-> SPEC_DEPTH == 3'h0 && !FLUSH && !FETCH_ACK)
		else $error("outputs not clear after reset");
	AST_ACK_ONCE: assert property (FETCH_ACK |=> !FETCH_ACK)
		else $error("fetch ack longer than one cycle");
	AST_ACK_CAUSE: assert property (FETCH_ACK |-> $past(FETCH_VALID))
		else $error("fetch ack without a line");
	AST_MISPRED: assert property (
		BR_RESOLVE && BR_MISPRED && SPEC_DEPTH != 3'h0 |=> FLUSH && CKPT_RESTORE && SPEC_DEPTH == 3'h0)
		else $error("misprediction not recovered");
	AST_RIGHT: assert property (BR_RESOLVE && !BR_MISPRED && SPEC_DEPTH != 3'h0 |=> CKPT_FREE && !FLUSH)
		else $error("correct branch not freed");
	AST_DEPTH_DROP: assert property (SPEC_DEPTH < $past(SPEC_DEPTH) |-> $past(BR_RESOLVE || FP_DONE) || FLUSH)
		else $error("depth fell without resolution");
	AST_DEPTH_RISE: assert property (SPEC_DEPTH > $past(SPEC_DEPTH) |-> CKPT_SAVE)
		else $error("depth rose without checkpoint");
	AST_EXCL_ALONE: assert property (EX_ASSIST |-> !OOO_COMPLETE)
		else $error("exclusive instruction had a companion");
	AST_STORE_HOLD: assert property (WBUF_FULL [*3] |=> WBUF_PUSH == 2'h0)
		else $error("store pushed into full buffers");
	AST_FLUSH_PULSE: assert property (FLUSH |=> !FLUSH && !CKPT_SAVE)
		else $error("flush not a clean pulse");
endmodule
bind dual_pipe_dispatch dpd_asserts #(.DEPTH_MAX(DEPTH_MAX)) u_chk (.CLK(CLK), .RST_N(RST_N),
	.FETCH_VALID(FETCH_VALID), .BR_RESOLVE(BR_RESOLVE), .BR_MISPRED(BR_MISPRED), .FP_DONE(FP_DONE),
	.WBUF_FULL(WBUF_FULL), .FETCH_ACK(FETCH_ACK), .FLUSH(FLUSH), .CKPT_SAVE(CKPT_SAVE),
	.CKPT_FREE(CKPT_FREE), .CKPT_RESTORE(CKPT_RESTORE), .SPEC_DEPTH(SPEC_DEPTH),
	.EX_ASSIST(EX_ASSIST), .OOO_COMPLETE(OOO_COMPLETE), .WBUF_PUSH(WBUF_PUSH));

/* File: dv/fetch_model.sv */
// Purpose: fetch partner feeding sixteen byte lines
// Assumes: a line is held until acknowledged or flushed
// Notes: gap sets idle cycles between lines for a slow fetch
`timescale 1ns/1ps
module fetch_model (
	input wire CLK,
	input wire RST_N,
	input wire FETCH_ACK,
	input wire FLUSH,
	output reg FETCH_VALID,
	output reg [127:0] FETCH_BYTES
);
	reg [127:0] lines[$];
	integer gap = 0;
	integer idle = 0;
	task put(input [127:0] l);
		lines.push_back(l);
	endtask
	initial begin
		FETCH_VALID = 1'b0;
		FETCH_BYTES = 128'h0;
	end
	always @(negedge CLK) begin
		if (FETCH_VALID && (FETCH_ACK || FLUSH)) begin
			lines.delete(0);
			FETCH_VALID <= 1'b0;
			FETCH_BYTES <= ~FETCH_BYTES;
			idle <= gap;
		end else if (!FETCH_VALID && RST_N && idle == 0 && lines.size() > 0) begin
			FETCH_VALID <= 1'b1;
			FETCH_BYTES <= lines[0];
		end else if (!FETCH_VALID) begin
			FETCH_BYTES <= ~FETCH_BYTES;
			if (idle > 0) idle <= idle - 1;
		end
	end
endmodule

/* File: dv/test_dual_pipe_dispatch.sv */
// Purpose: self-checking bench for the dual pipe dispatch block
// Assumes: fetch_model supplies lines, bench drives the rest at falling edges
// Notes: checkpoint events are compared through expectation queues
`timescale 1ns/1ps
module test_dual_pipe_dispatch;
	reg CLK = 1'b0;
	reg RST_N = 1'b0;
	reg [1:0] EX_READY = 2'h0;
	reg [1:0] EX_FAULT = 2'h0;
	reg BR_RESOLVE = 1'b0;
	reg BR_MISPRED = 1'b0;
	reg FP_DONE = 1'b0;
	reg WBUF_FULL = 1'b0;
	wire FETCH_VALID, FETCH_ACK, FLUSH, CKPT_SAVE, CKPT_FREE, CKPT_RESTORE;
	wire EX_ASSIST, FPU_ISSUE, OOO_COMPLETE, EXC_REPORT;
	wire [127:0] FETCH_BYTES;
	wire [1:0] SAVE_ID, FREE_ID, AGU_REQ, A2_ACCESS, RF_WRITE, WBUF_PUSH;
	wire [2:0] SPEC_DEPTH;
	integer failures = 0;
	integer num_checks = 0;
	integer dep = 0, n_sv = 0, n_fr = 0, n_fl = 0, n_fp = 0, n_ooo = 0, n_exc = 0, n_asst = 0;
	integer n_rf = 0, n_wb = 0, n_agu = 0, n_a2 = 0, e_rf, e_wb, e_agu, e_a2, i, k;
	reg [2:0] sq[$];
	reg [2:0] fq[$];
	reg track = 1'b0;
	reg asst_q = 1'b0;
	reg [127:0] line;
	reg [3:0] cls;
	initial begin
		forever #2.5 CLK = ~CLK;
	end
	dual_pipe_dispatch u_dut (.CLK(CLK), .RST_N(RST_N), .FETCH_VALID(FETCH_VALID), .FETCH_BYTES(FETCH_BYTES),
		.EX_READY(EX_READY), .EX_FAULT(EX_FAULT), .BR_RESOLVE(BR_RESOLVE), .BR_MISPRED(BR_MISPRED),
		.FP_DONE(FP_DONE), .WBUF_FULL(WBUF_FULL), .FETCH_ACK(FETCH_ACK), .FLUSH(FLUSH), .CKPT_SAVE(CKPT_SAVE),
		.SAVE_ID(SAVE_ID), .CKPT_FREE(CKPT_FREE), .CKPT_RESTORE(CKPT_RESTORE), .FREE_ID(FREE_ID),
		.SPEC_DEPTH(SPEC_DEPTH), .AGU_REQ(AGU_REQ), .A2_ACCESS(A2_ACCESS), .EX_ASSIST(EX_ASSIST),
		.FPU_ISSUE(FPU_ISSUE), .OOO_COMPLETE(OOO_COMPLETE), .RF_WRITE(RF_WRITE), .WBUF_PUSH(WBUF_PUSH),
		.EXC_REPORT(EXC_REPORT));
	fetch_model u_fetch (.CLK(CLK), .RST_N(RST_N), .FETCH_ACK(FETCH_ACK), .FLUSH(FLUSH),
		.FETCH_VALID(FETCH_VALID), .FETCH_BYTES(FETCH_BYTES));
	task chk(input [31:0] got, input [31:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wait_cnt(ref integer c, input integer v);
		integer t;
		for (t = 0; t < 300 && c != v; t = t + 1)
			@(posedge CLK);
		chk(c, v);
	endtask
	task pulse(input r, input m);
		@(negedge CLK);
		BR_RESOLVE = r;
		BR_MISPRED = m;
		FP_DONE = !r;
		@(negedge CLK);
		BR_RESOLVE = 1'b0;
		BR_MISPRED = 1'b0;
		FP_DONE = 1'b0;
	endtask
	task say(input [63:0] s);
		$display("test %0s done", s);
	endtask
	task finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// result watcher: counts pulses, compares checkpoint events against the queues
	always @(negedge CLK) begin
		if (RST_N) begin
			dep = SPEC_DEPTH;
			n_rf = n_rf + $countones(RF_WRITE);
			n_wb = n_wb + $countones(WBUF_PUSH);
			n_agu = n_agu + $countones(AGU_REQ);
			n_a2 = n_a2 + $countones(A2_ACCESS);
			n_fl = n_fl + FLUSH;
			n_fp = n_fp + FPU_ISSUE;
			n_ooo = n_ooo + OOO_COMPLETE;
			n_exc = n_exc + EXC_REPORT;
			n_asst = n_asst + (EX_ASSIST && !asst_q);
			asst_q = EX_ASSIST;
			if (CKPT_SAVE) begin
				n_sv = n_sv + 1;
				if (track) chk(SAVE_ID, sq.size() ? sq.pop_front() : 3'h7);
			end
			if (CKPT_FREE || CKPT_RESTORE) begin
				n_fr = n_fr + 1;
				if (track) chk({CKPT_RESTORE, FREE_ID}, fq.size() ? fq.pop_front() : 3'h7);
			end
		end
	end
	// whole run needs a few hundred cycles, allow many times that
	initial begin
		#200000;
		failures = failures + 1;
		finish_test;
	end
	initial begin
		i = $urandom(12);
		repeat (2) @(negedge CLK);
		RST_N = 1'b1;
		@(posedge CLK);
		#1 chk({SPEC_DEPTH, FLUSH, CKPT_SAVE, FETCH_ACK}, 0);
		say("reset");
		track = 1'b1;
		for (i = 0; i < 5; i = i + 1)
			sq.push_back(i[1:0]);
		fq.push_back(3'h0);
		fq.push_back(3'h5);
		u_fetch.put({{11{8'h00}}, {5{8'h30}}});
		wait_cnt(dep, 4);
		repeat (10) @(posedge CLK);
		chk(n_sv, 4);
		pulse(1, 0);
		wait_cnt(n_sv, 5);
		pulse(1, 1);
		wait_cnt(dep, 0);
		pulse(1, 0);
		repeat (4) @(posedge CLK);
		chk(n_fl, 1);
		chk(n_fr + sq.size() + fq.size(), 2);
		track = 1'b0;
		say("branch");
		u_fetch.put({{10{8'h00}}, {6{8'h40}}});
		wait_cnt(n_fp, 4);
		repeat (10) @(posedge CLK);
		chk(n_fp + dep, 8);
		for (i = 0; i < 6; i = i + 1)
			pulse(0, 0);
		wait_cnt(n_fp, 6);
		wait_cnt(dep, 0);
		say("fp");
		u_fetch.put({{14{8'h00}}, 8'h00, 8'hD0});
		wait_cnt(n_ooo, 1);
		@(negedge CLK);
		EX_READY = 2'h3;
		say("ooo");
		for (k = 5; k < 13; k = k + 1) begin
			cls = k[3:0];
			u_fetch.put({{14{8'h00}}, 8'h00, cls, 4'h0});
			wait_cnt(n_asst, k - 4);
		end
		say("excl");
		repeat (20) @(posedge CLK);
		@(negedge CLK);
		EX_FAULT = 2'h1;
		u_fetch.put({16{8'h00}});
		wait_cnt(n_exc, 1);
		@(negedge CLK);
		EX_FAULT = 2'h0;
		wait_cnt(n_fl, 2);
		say("fault");
		repeat (20) @(posedge CLK);
		e_rf = n_rf;
		e_wb = n_wb;
		e_agu = n_agu;
		e_a2 = n_a2 + 8 * 16;
		u_fetch.gap = 3;
		for (i = 0; i < 8; i = i + 1) begin
			for (k = 0; k < 16; k = k + 1) begin
				cls = 4'(16'hD210 >> (4 * ($urandom % 4)));
				line[8*k +: 8] = {cls, 4'h0};
				e_rf = e_rf + (cls != 4'h2);
				e_wb = e_wb + (cls == 4'h2);
				e_agu = e_agu + (cls != 4'h0);
			end
			u_fetch.put(line);
		end
		repeat (200) begin
			@(negedge CLK);
			EX_READY = 2'($urandom);
			WBUF_FULL = 1'($urandom);
		end
		@(negedge CLK);
		EX_READY = 2'h3;
		WBUF_FULL = 1'b0;
		wait_cnt(n_rf, e_rf);
		wait_cnt(n_wb, e_wb);
		wait_cnt(n_agu, e_agu);
		wait_cnt(n_a2, e_a2);
		say("random");
		finish_test;
	end
endmodule

/* File: src/dispatch_map.vh */
// Purpose: constants for the dual pipeline dispatch and speculation control
// Assumes: one opcode byte per instruction, length in low nibble, class in high
// Notes: included by every design file of this block
// What this block does
// - length stage sizes, decode stage classifies and steers
// - branch, fp, exclusive go only to x pipe
// - branch or fp may pair with y instruction
// - exclusive issues alone, y ex slot assists
// - decoder marks listed system-like classes exclusive
// - first address stage requests up to two addresses
// - second address stage requests tlb, cache, regfile access
// - alu with cache operand executes in one clock
// - issue continues past predicted branches and fp ops
// - prediction saves checkpoint and raises depth counter
// - no more than four speculation levels active
// - resolution lowers depth counter before acting
// - correct prediction frees checkpoint, stream continues
// - misprediction flushes, restores checkpoint, refetches at length stage
// - speculative stores held until their branch resolves
// - speculation halts at max depth, fault, full buffers, system writes
// - out of order only for ready y past multicycle x
// - ready instruction completes ahead of stalled older one
// - ex entry, exceptions and writes stay in order
// - write-back updates regfile, write buffers, machine state
// - fp queue of four outstanding operations
// - fetch line of sixteen bytes feeds length stage
`ifndef DISPATCH_MAP_VH
`define DISPATCH_MAP_VH
`define LINE_BYTES 5'h10
`define OP_LEN 3:0
`define OP_CLS 7:4
`define C_ALU 4'h0
`define C_ALU_MEM 4'h1
`define C_STORE 4'h2
`define C_BRANCH 4'h3
`define C_FP 4'h4
`define C_SEGLOAD 4'h5
`define C_CTLREG 4'h6
`define C_STRING 4'h7
`define C_MULDIV 4'h8
`define C_IO 4'h9
`define C_PUSH_ALL 4'hA
`define C_POP_ALL 4'hB
`define C_TASKSW 4'hC
`define C_LOAD 4'hD
`define FW 7
`define F_SPEC 0
`define F_FP 1
`define F_EXCL 2
`define F_MEM 3
`define F_MULTI 4
`define F_STORE 5
`define F_SYS 6
`define SPEC_MAX 3'h4
`define FPQ_MAX 3'h4
`endif

/* File: src/dual_pipe_dispatch.v */
// Purpose: decode to write-back control of the x and y integer pipes
// Assumes: branch and fp resolutions arrive oldest first, one per cycle
// Notes: all outputs registered, event outputs lag their cause by one cycle
`timescale 1ns/1ps
`include "dispatch_map.vh"
module dual_pipe_dispatch #(
	parameter [2:0] DEPTH_MAX = `SPEC_MAX,
	parameter [2:0] FPQ_DEPTH = `FPQ_MAX
) (
	input wire CLK,
	input wire RST_N,
	input wire FETCH_VALID,
	input wire [127:0] FETCH_BYTES,
	input wire [1:0] EX_READY,
	input wire [1:0] EX_FAULT,
	input wire BR_RESOLVE,
	input wire BR_MISPRED,
	input wire FP_DONE,
	input wire WBUF_FULL,
	output reg FETCH_ACK,
	output reg FLUSH,
	output reg CKPT_SAVE,
	output reg [1:0] SAVE_ID,
	output reg CKPT_FREE,
	output reg CKPT_RESTORE,
	output reg [1:0] FREE_ID,
	output reg [2:0] SPEC_DEPTH,
	output reg [1:0] AGU_REQ,
	output reg [1:0] A2_ACCESS,
	output reg EX_ASSIST,
	output reg FPU_ISSUE,
	output reg OOO_COMPLETE,
	output reg [1:0] RF_WRITE,
	output reg [1:0] WBUF_PUSH,
	output reg EXC_REPORT
);
	reg [127:0] line;
	reg line_v;
	reg [4:0] ptr;
	reg [1:0] ldv;
	reg [7:0] ldo0;
	reg [7:0] ldo1;
	reg [1:0] fdv;
	reg [1:0] a1v;
	reg [1:0] a2v;
	reg [1:0] exv;
	reg [1:0] wbv;
	reg [`FW-1:0] fdf0;
	reg [`FW-1:0] fdf1;
	reg [`FW-1:0] a1f0;
	reg [`FW-1:0] a1f1;
	reg [`FW-1:0] a2f0;
	reg [`FW-1:0] a2f1;
	reg [`FW-1:0] exf0;
	reg [`FW-1:0] exf1;
	reg [`FW-1:0] wbf0;
	reg [`FW-1:0] wbf1;
	reg [3:0] sq_a1;
	reg [3:0] sq_a2;
	reg [3:0] exs0;
	reg [3:0] exs1;
	reg [3:0] wbs0;
	reg [3:0] wbs1;
	reg [1:0] wbx;
	reg [2:0] depth;
	reg [3:0] acnt;
	reg [3:0] rcnt;
	reg [2:0] fpcnt;
	reg sys_busy;

	// length stage: size up to two instructions of the fetched line
	wire [7:0] b0 = line[{ptr[3:0], 3'b000} +: 8];
	wire [4:0] l0 = {1'b0, b0[`OP_LEN]} + 5'h01;
	wire [4:0] p1 = ptr + l0;
	wire [7:0] b1 = line[{p1[3:0], 3'b000} +: 8];
	wire [4:0] l1 = {1'b0, b1[`OP_LEN]} + 5'h01;
	wire [5:0] e1 = {1'b0, p1} + {1'b0, l1};
	wire c0 = line_v & (p1 <= `LINE_BYTES);
	wire c1 = c0 & (p1 < `LINE_BYTES) & (e1 <= {1'b0, `LINE_BYTES});
	wire [4:0] np = c1 ? e1[4:0] : p1;

	// full decode of the two held candidates
	wire [`FW-1:0] k0;
	wire [`FW-1:0] k1;
	insn_class u_cls0 (
		.cls(ldo0[`OP_CLS]),
		.flags(k0)
	);
	insn_class u_cls1 (
		.cls(ldo1[`OP_CLS]),
		.flags(k1)
	);
	// second goes to y unless it is x-only or the first is exclusive
	wire pair = ldv[1] & ~k0[`F_EXCL] & ~k1[`F_SPEC] & ~k1[`F_EXCL];

	// speculation gate at the decode to address boundary
	wire xs = fdv[0] & fdf0[`F_SPEC];
	wire xsys = fdv[0] & fdf0[`F_SYS];
	wire spec_block = xs & ((depth >= DEPTH_MAX) | WBUF_FULL | sys_busy);
	wire sys_block = xsys & ((depth != 3'h0) | sys_busy);

	// execute and write-back hand-off
	wire dn0 = ~exf0[`F_MULTI] | EX_READY[0];
	wire dn1 = ~exf1[`F_MULTI] | EX_READY[1];
	wire [3:0] d0 = wbs0 - rcnt;
	wire [3:0] d1 = wbs1 - rcnt;
	wire uns0 = (d0 != 4'h0) & (d0 <= {1'b0, DEPTH_MAX});
	wire uns1 = (d1 != 4'h0) & (d1 <= {1'b0, DEPTH_MAX});
	wire wbh0 = wbv[0] & wbf0[`F_STORE] & (uns0 | WBUF_FULL);
	wire wbh1 = wbv[1] & ((wbf1[`F_STORE] & (uns1 | WBUF_FULL)) | wbh0);
	wire wbfree0 = ~wbv[0] | ~wbh0;
	wire wbfree1 = ~wbv[1] | ~wbh1;
	wire ooo = exv[0] & ~dn0 & exf0[`F_MULTI] & ~exf1[`F_STORE] & ~EX_FAULT[1];
	wire exl0 = exv[0] & dn0 & wbfree0 & ~wbh1;
	wire exl1 = exv[1] & dn1 & wbfree1 & (~exv[0] | exl0 | ooo);
	wire exfree0 = ~exv[0] | exl0;
	wire exfree1 = ~exv[1] | exl1;
	wire com0 = wbv[0] & ~wbh0;
	wire exc0 = com0 & wbx[0];
	wire com1 = wbv[1] & ~wbh1 & ~exc0;
	wire exc1 = com1 & wbx[1];
	wire exc = exc0 | exc1;

	// speculation resolution
	wire res = (BR_RESOLVE | FP_DONE) & (depth != 3'h0);
	wire mis = res & BR_RESOLVE & BR_MISPRED;
	wire flush = mis | exc;
	wire fq_full = fpcnt >= FPQ_DEPTH;

	// stage advance, pairs move as one unit until execute
	wire a2_go = a2v[0] & exfree0 & (~(a2v[1] | a2f0[`F_EXCL]) | exfree1) & ~(a2f0[`F_FP] & fq_full);
	wire a1_go = a1v[0] & (~a2v[0] | a2_go);
	wire fd_go = fdv[0] & (~a1v[0] | a1_go) & ~spec_block & ~sys_block;
	wire fd_ok = ldv[0] & (~fdv[0] | fd_go);
	wire ld_empty = ~ldv[0] | (fd_ok & (pair | ~ldv[1]));
	wire alloc = fd_go & xs & ~flush;
	wire cap = FETCH_VALID & ~line_v & ~FETCH_ACK & ~flush;

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			line <= 128'h0;
			line_v <= 1'b0;
			ptr <= 5'h00;
			ldv <= 2'h0;
			ldo0 <= 8'h00;
			ldo1 <= 8'h00;
		end else if (flush) begin
			line_v <= 1'b0;
			ptr <= 5'h00;
			ldv <= 2'h0;
		end else begin
			if (cap) begin
				line <= FETCH_BYTES;
				line_v <= 1'b1;
				ptr <= 5'h00;
			end else if (ld_empty & line_v) begin
				if (c0) begin
					ptr <= np;
					if (np >= `LINE_BYTES)
						line_v <= 1'b0;
				end else begin
					line_v <= 1'b0;
					ptr <= 5'h00;
				end
			end
			if (ld_empty & c0 & ~cap) begin
				ldv <= {c1, 1'b1};
				ldo0 <= b0;
				ldo1 <= b1;
			end else if (fd_ok & ~pair & ldv[1]) begin
				ldv <= 2'h1;
				ldo0 <= ldo1;
			end else if (ld_empty) begin
				ldv <= 2'h0;
			end
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			fdv <= 2'h0;
			a1v <= 2'h0;
			a2v <= 2'h0;
			exv <= 2'h0;
			fdf0 <= {`FW{1'b0}};
			fdf1 <= {`FW{1'b0}};
			a1f0 <= {`FW{1'b0}};
			a1f1 <= {`FW{1'b0}};
			a2f0 <= {`FW{1'b0}};
			a2f1 <= {`FW{1'b0}};
			exf0 <= {`FW{1'b0}};
			exf1 <= {`FW{1'b0}};
			sq_a1 <= 4'h0;
			sq_a2 <= 4'h0;
			exs0 <= 4'h0;
			exs1 <= 4'h0;
		end else if (flush) begin
			fdv <= 2'h0;
			a1v <= 2'h0;
			a2v <= 2'h0;
			exv <= 2'h0;
		end else begin
			if (fd_ok) begin
				fdv <= {pair, 1'b1};
				fdf0 <= k0;
				fdf1 <= k1;
			end else if (fd_go) begin
				fdv <= 2'h0;
			end
			if (fd_go) begin
				a1v <= fdv;
				a1f0 <= fdf0;
				a1f1 <= fdf1;
				sq_a1 <= acnt + {3'h0, xs};
			end else if (a1_go) begin
				a1v <= 2'h0;
			end
			if (a1_go) begin
				a2v <= a1v;
				a2f0 <= a1f0;
				a2f1 <= a1f1;
				sq_a2 <= sq_a1;
			end else if (a2_go) begin
				a2v <= 2'h0;
			end
			if (a2_go) begin
				exv[0] <= 1'b1;
				exf0 <= a2f0;
				exs0 <= sq_a2;
			end else if (exl0) begin
				exv[0] <= 1'b0;
			end
			if (a2_go) begin
				exv[1] <= a2v[1];
				exf1 <= a2f1;
				exs1 <= sq_a2;
			end else if (exl1) begin
				exv[1] <= 1'b0;
			end
		end
	end

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wbv <= 2'h0;
			wbf0 <= {`FW{1'b0}};
			wbf1 <= {`FW{1'b0}};
			wbs0 <= 4'h0;
			wbs1 <= 4'h0;
			wbx <= 2'h0;
		end else if (exc) begin
			wbv <= 2'h0;
		end else begin
			// a resolving branch still leaves execute; its y mate is younger
			if (exl0) begin
				wbv[0] <= 1'b1;
				wbf0 <= exf0;
				wbs0 <= exs0;
				wbx[0] <= EX_FAULT[0];
			end else if (com0) begin
				wbv[0] <= 1'b0;
			end
			if (exl1 & ~mis) begin
				wbv[1] <= 1'b1;
				wbf1 <= exf1;
				wbs1 <= exs1;
				wbx[1] <= EX_FAULT[1];
			end else if (com1) begin
				wbv[1] <= 1'b0;
			end
		end
	end

	// speculation depth, checkpoint ids and fp queue count
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			depth <= 3'h0;
			acnt <= 4'h0;
			rcnt <= 4'h0;
			fpcnt <= 3'h0;
			sys_busy <= 1'b0;
		end else begin
			if (flush) begin
				depth <= 3'h0;
				acnt <= rcnt + {3'h0, res};
			end else begin
				depth <= depth + {2'h0, alloc} - {2'h0, res};
				acnt <= acnt + {3'h0, alloc};
			end
			rcnt <= rcnt + {3'h0, res};
			if (flush)
				fpcnt <= 3'h0;
			else
				fpcnt <= fpcnt + {2'h0, a2_go & a2f0[`F_FP]} - {2'h0, FP_DONE & (fpcnt != 3'h0)};
			if (flush | (com0 & wbf0[`F_SYS]))
				sys_busy <= 1'b0;
			else if (fd_go & xsys)
				sys_busy <= 1'b1;
		end
	end

	// registered outputs, one cycle after their cause
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			FETCH_ACK <= 1'b0;
			FLUSH <= 1'b0;
			CKPT_SAVE <= 1'b0;
			SAVE_ID <= 2'h0;
			CKPT_FREE <= 1'b0;
			CKPT_RESTORE <= 1'b0;
			FREE_ID <= 2'h0;
			SPEC_DEPTH <= 3'h0;
			AGU_REQ <= 2'h0;
			A2_ACCESS <= 2'h0;
			EX_ASSIST <= 1'b0;
			FPU_ISSUE <= 1'b0;
			OOO_COMPLETE <= 1'b0;
			RF_WRITE <= 2'h0;
			WBUF_PUSH <= 2'h0;
			EXC_REPORT <= 1'b0;
		end else begin
			FETCH_ACK <= cap;
			FLUSH <= flush;
			CKPT_SAVE <= alloc;
			SAVE_ID <= acnt[1:0];
			CKPT_FREE <= res & ~mis;
			CKPT_RESTORE <= mis;
			FREE_ID <= rcnt[1:0];
			SPEC_DEPTH <= flush ? 3'h0 : depth + {2'h0, alloc} - {2'h0, res};
			AGU_REQ <= (a1_go & ~flush) ? {a1v[1] & a1f1[`F_MEM], a1f0[`F_MEM]} : 2'h0;
			A2_ACCESS <= (a2_go & ~flush) ? a2v : 2'h0;
			EX_ASSIST <= exv[0] & exf0[`F_EXCL] & ~flush;
			FPU_ISSUE <= a2_go & a2f0[`F_FP] & ~flush;
			OOO_COMPLETE <= exl1 & ooo & ~flush;
			RF_WRITE <= {com1 & ~wbx[1] & ~wbf1[`F_STORE], com0 & ~wbx[0] & ~wbf0[`F_STORE]};
			WBUF_PUSH <= {com1 & ~wbx[1] & wbf1[`F_STORE], com0 & ~wbx[0] & wbf0[`F_STORE]};
			EXC_REPORT <= exc;
		end
	end
endmodule

/* File: src/insn_class.v */
// Purpose: turns an instruction class code into steering flags
// Assumes: class codes from dispatch_map.vh
// Notes: pure combinational, one instance per decode slot
`timescale 1ns/1ps
`include "dispatch_map.vh"
module insn_class (
	input wire [3:0] cls,
	output wire [`FW-1:0] flags
);
	wire excl;
	assign excl = (cls == `C_SEGLOAD) | (cls == `C_CTLREG) | (cls == `C_STRING) | (cls == `C_MULDIV) |
		(cls == `C_IO) | (cls == `C_PUSH_ALL) | (cls == `C_POP_ALL) | (cls == `C_TASKSW);
	assign flags[`F_SPEC] = (cls == `C_BRANCH) | (cls == `C_FP);
	assign flags[`F_FP] = (cls == `C_FP);
	assign flags[`F_EXCL] = excl;
	assign flags[`F_MEM] = (cls == `C_ALU_MEM) | (cls == `C_STORE) | (cls == `C_LOAD) | (cls == `C_STRING) |
		(cls == `C_SEGLOAD) | (cls == `C_PUSH_ALL) | (cls == `C_POP_ALL);
	// alu with cache operand is single cycle, operand came from address stages
	assign flags[`F_MULTI] = excl | (cls == `C_LOAD);
	assign flags[`F_STORE] = (cls == `C_STORE);
	assign flags[`F_SYS] = (cls == `C_CTLREG) | (cls == `C_TASKSW);
endmodule
